// ---- rtl/fault_indicator_regs.vh ----
/*
 Constants for the collective fault indicator: limits, code numbers, timing.
 Assumes a 100 MHz system clock and measured values in fixed units.
*/
`ifndef FAULT_INDICATOR_REGS_VH
`define FAULT_INDICATOR_REGS_VH

// ----------------------------------------
// measurement limits
// ----------------------------------------
// output voltages in units of 0.1 V
`define OUT_LOW_LIMIT_DV 12'h104
`define OUT_HIGH_LIMIT_DV 12'h124
// temperatures in signed whole degrees celsius
`define BAT_TEMP_HIGH_C 8'h41
`define SENSOR_TEMP_LOW_C 8'hEC
`define SENSOR_TEMP_HIGH_C 8'h50

// ----------------------------------------
// fault code count
// ----------------------------------------
`define FAULT_CODES 22
`define CODE_W 5

// ----------------------------------------
// timing, 100 MHz clock
// ----------------------------------------
`define CLK_HZ 100000000
// one second in cycles, 36 bits so that a minute does not overflow
`define SEC_CYC 36'h0_05F5_E100
`define MAINS_DELAY_S 10
`define MAINS_DELAY_CYC (`MAINS_DELAY_S * `SEC_CYC)
`define OVERLOAD_LIMIT_S 60
`define OVERLOAD_LIMIT_CYC (`OVERLOAD_LIMIT_S * `SEC_CYC)
`define FLASH_ON_MS 200
`define FLASH_ON_CYC (`FLASH_ON_MS * (`CLK_HZ / 1000))
`define FLASH_OFF_MS 300
`define FLASH_OFF_CYC (`FLASH_OFF_MS * (`CLK_HZ / 1000))
`define CODE_PAUSE_MS 2000
`define CODE_PAUSE_CYC (`CODE_PAUSE_MS * (`CLK_HZ / 1000))

`endif

// ---- rtl/delay_timer.v ----
/*
 One-shot timer: counts while run_in is high, done when the count reaches limit.
 Assumes a single synchronous clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module delay_timer #(
   parameter [35:0] LIMIT = 36'h0_0000_0010
) (
   input wire sys_clk_in,
   input wire rst_n_in,
   input wire run_in,
   output wire done_out
);

   // wide enough for a full minute at the system clock
   reg [35:0] count_r;
   wire [35:0] count_nxt;

   assign done_out = (count_r == LIMIT);
   assign count_nxt = !run_in ? 36'h0_0000_0000 :
                      (done_out ? count_r : count_r + 36'h0_0000_0001);

   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_r <= 36'h0_0000_0000;
      end else begin
         count_r <= count_nxt;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/flash_sequencer.v ----
/*
 Status LED sequencer: shows each pending fault as a burst of flashes,
 then a long pause, then moves on to the next pending fault.
 Assumes fault vector bit n-1 stands for flash count n.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fault_indicator_regs.vh"

module flash_sequencer #(
   parameter [31:0] ON_CYC = `FLASH_ON_CYC,
   parameter [31:0] OFF_CYC = `FLASH_OFF_CYC,
   parameter [31:0] PAUSE_CYC = `CODE_PAUSE_CYC
) (
   input wire sys_clk_in,
   input wire rst_n_in,
   input wire [`FAULT_CODES-1:0] faults_in,
   output reg led_out,
   output reg [`CODE_W-1:0] code_out
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ON = 2'h1;
   localparam [1:0] ST_OFF = 2'h2;
   localparam [1:0] ST_PAUSE = 2'h3;

   reg [1:0] state_r;
   reg [31:0] timer_r;
   reg [`CODE_W-1:0] flashes_r;
   reg [`CODE_W-1:0] next_code;
   integer i;

   // next pending code after the current one, wrapping round
   always @* begin
      next_code = {`CODE_W{1'b0}};
      // lowest pending code, used when nothing above the current one waits
      for (i = `FAULT_CODES; i >= 1; i = i - 1) begin
         if (faults_in[i-1]) begin
            next_code = i[`CODE_W-1:0];
         end
      end
      for (i = `FAULT_CODES; i >= 1; i = i - 1) begin
         if (faults_in[i-1] && (i > code_out)) begin
            next_code = i[`CODE_W-1:0];
         end
      end
   end

   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= ST_IDLE;
         timer_r <= 32'h0000_0000;
         flashes_r <= {`CODE_W{1'b0}};
         led_out <= 1'b0;
         code_out <= {`CODE_W{1'b0}};
      end else begin
         case (state_r)
            ST_IDLE: begin
               led_out <= 1'b0;
               if (next_code != 0) begin
                  code_out <= next_code;
                  flashes_r <= 5'h01;
                  led_out <= 1'b1;
                  timer_r <= 32'h0000_0000;
                  state_r <= ST_ON;
               end
            end
            ST_ON: begin
               if (timer_r >= ON_CYC - 32'h0000_0001) begin
                  timer_r <= 32'h0000_0000;
                  led_out <= 1'b0;
                  state_r <= (flashes_r >= code_out) ? ST_PAUSE : ST_OFF;
               end else begin
                  timer_r <= timer_r + 32'h0000_0001;
               end
            end
            ST_OFF: begin
               if (timer_r >= OFF_CYC - 32'h0000_0001) begin
                  timer_r <= 32'h0000_0000;
                  flashes_r <= flashes_r + 5'h01;
                  led_out <= 1'b1;
                  state_r <= ST_ON;
               end else begin
                  timer_r <= timer_r + 32'h0000_0001;
               end
            end
            ST_PAUSE: begin
               if (timer_r >= PAUSE_CYC - 32'h0000_0001) begin
                  timer_r <= 32'h0000_0000;
                  state_r <= ST_IDLE;
               end else begin
                  timer_r <= timer_r + 32'h0000_0001;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               led_out <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- rtl/collective_fault_indicator.v ----
/*
 Collective fault supervision: gathers fault conditions, drives the
 collective fault relay, the mains-loss relay, the status LED and the
 charge-limit request. Assumes inputs synchronous to sys_clk_in and
 measurements already converted by outside logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fault_indicator_regs.vh"

// What this block does
// - collective fault on mains loss, battery circuit fail, supply fail, external input.
// - battery, resistance, continuity, charger, fuse, overload, cover, damage all fault.
// - either load output below 26 V flags a fault.
// - either load output above 29.2 V flags a fault.
// - battery temperature above 65 C flags a fault.
// - temperature below -20 C or above 80 C means sensor failure.
// - fault releases the relay coil, so supply loss also reads as fault.
// - each fault except internal damage flashes its count on the LED, several shown in turn.
// - counts 1 to 9 map mains, fuse one, overload ... external input.
// - counts 10 to 18 map sensor, temperature ... low output two.
// - counts 19, 20, 21 single service codes; 22 shared by nine more.
// - open external fault terminals mean an active external fault.
// - open enclosure tamper switch raises a collective fault.
// - factory jumper reads as closed tamper, no tamper fault.
// - overload limits charging one minute, then resumes if overload gone.
// - blown output fuse shows on LED and collective output until replaced.
// - fuse strip feeds external input; device then reports collective fault.
// - mains loss waits 10 s before switching mains and collective outputs.
module collective_fault_indicator #(
   parameter [35:0] MAINS_DELAY_CYC = `MAINS_DELAY_CYC,
   parameter [35:0] OVERLOAD_LIMIT_CYC = `OVERLOAD_LIMIT_CYC,
   parameter [31:0] FLASH_ON_CYC = `FLASH_ON_CYC,
   parameter [31:0] FLASH_OFF_CYC = `FLASH_OFF_CYC,
   parameter [31:0] CODE_PAUSE_CYC = `CODE_PAUSE_CYC
) (
   input wire sys_clk_in,
   input wire rst_n_in,
   input wire mains_present_in,
   input wire [11:0] load_output_one_dv_in,
   input wire [11:0] load_output_two_dv_in,
   input wire output_one_fuse_blown_in,
   input wire output_two_fuse_blown_in,
   input wire overload_in,
   input wire [7:0] bat_temp_c_in,
   input wire battery_absent_in,
   input wire battery_faulty_in,
   input wire battery_undercharged_in,
   input wire battery_low_in,
   input wire bat_resistance_high_in,
   input wire bat_continuity_lost_in,
   input wire charger_fail_in,
   input wire internal_damage_in,
   input wire external_fault_in,
   input wire tamper_closed_in,
   input wire [2:0] service_single_in,
   input wire [8:0] service_group_in,
   output reg fault_relay_energised_out,
   output reg mains_loss_out,
   output wire status_led_out,
   output wire [`CODE_W-1:0] shown_code_out,
   output reg charge_limit_out,
   output reg [`FAULT_CODES-1:0] faults_out
);

   // ----------------------------------------
   // measurement comparisons
   // ----------------------------------------
   wire out1_low = load_output_one_dv_in < `OUT_LOW_LIMIT_DV;
   wire out2_low = load_output_two_dv_in < `OUT_LOW_LIMIT_DV;
   wire out1_high = load_output_one_dv_in > `OUT_HIGH_LIMIT_DV;
   wire out2_high = load_output_two_dv_in > `OUT_HIGH_LIMIT_DV;
   wire signed [7:0] temp_s = bat_temp_c_in;
   wire sensor_fail = (temp_s < $signed(`SENSOR_TEMP_LOW_C)) ||
                      (temp_s > $signed(`SENSOR_TEMP_HIGH_C));
   wire temp_high = !sensor_fail && (temp_s > $signed(`BAT_TEMP_HIGH_C));
   // input high means the loop is closed; open loop is a fault
   wire ext_active = !external_fault_in;
   // jumper or closed switch reads high
   wire tamper_open = !tamper_closed_in;

   // ----------------------------------------
   // mains loss delay
   // ----------------------------------------
   wire mains_done;

   delay_timer #(
      .LIMIT(MAINS_DELAY_CYC)
   ) mains_timer (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .run_in(!mains_present_in),
      .done_out(mains_done)
   );

   // ----------------------------------------
   // overload charge limiting
   // ----------------------------------------
   wire overload_done;
   reg limit_run_r;

   delay_timer #(
      .LIMIT(OVERLOAD_LIMIT_CYC)
   ) overload_timer (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .run_in(limit_run_r),
      .done_out(overload_done)
   );

   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         limit_run_r <= 1'b0;
         charge_limit_out <= 1'b0;
      end else begin
         if (!limit_run_r) begin
            if (overload_in) begin
               limit_run_r <= 1'b1;
               charge_limit_out <= 1'b1;
            end
         end else if (overload_done) begin
            // restart the minute while overload persists
            limit_run_r <= 1'b0;
            charge_limit_out <= overload_in;
         end
      end
   end

   // ----------------------------------------
   // fault vector, bit n-1 is flash count n
   // ----------------------------------------
   reg [`FAULT_CODES-1:0] faults_nxt;

   always @* begin
      faults_nxt = {`FAULT_CODES{1'b0}};
      faults_nxt[0] = mains_done;
      faults_nxt[1] = output_one_fuse_blown_in;
      faults_nxt[2] = overload_in;
      faults_nxt[3] = battery_undercharged_in;
      faults_nxt[4] = out1_high;
      faults_nxt[5] = charger_fail_in;
      faults_nxt[6] = out1_low;
      faults_nxt[7] = battery_low_in;
      faults_nxt[8] = ext_active;
      faults_nxt[9] = sensor_fail;
      faults_nxt[10] = temp_high;
      faults_nxt[11] = battery_absent_in;
      faults_nxt[12] = battery_faulty_in || bat_continuity_lost_in;
      faults_nxt[13] = bat_resistance_high_in;
      faults_nxt[14] = tamper_open;
      faults_nxt[15] = output_two_fuse_blown_in;
      faults_nxt[16] = out2_high;
      faults_nxt[17] = out2_low;
      faults_nxt[20:18] = service_single_in;
      faults_nxt[21] = |service_group_in;
   end

   // ----------------------------------------
   // relay outputs
   // ----------------------------------------
   wire any_fault = |faults_nxt || internal_damage_in;

   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         faults_out <= {`FAULT_CODES{1'b0}};
         fault_relay_energised_out <= 1'b0;
         mains_loss_out <= 1'b0;
      end else begin
         faults_out <= faults_nxt;
         fault_relay_energised_out <= !any_fault;
         mains_loss_out <= mains_done;
      end
   end

   // ----------------------------------------
   // status LED
   // ----------------------------------------
   wire [`FAULT_CODES-1:0] led_faults = faults_nxt | {{(`FAULT_CODES-1){1'b0}}, ~mains_present_in};

   flash_sequencer #(
      .ON_CYC(FLASH_ON_CYC),
      .OFF_CYC(FLASH_OFF_CYC),
      .PAUSE_CYC(CODE_PAUSE_CYC)
   ) led_seq (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .faults_in(led_faults),
      .led_out(status_led_out),
      .code_out(shown_code_out)
   );

endmodule

`default_nettype wire

// ---- testbench/collective_fault_props.sv ----
/*
 Port checker for the collective fault indicator.
 Assumes the small timing parameters used by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module collective_fault_props (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic mains_present_in,
   input wire logic [11:0] load_output_one_dv_in,
   input wire logic [11:0] load_output_two_dv_in,
   input wire logic output_one_fuse_blown_in,
   input wire logic overload_in,
   input wire logic [7:0] bat_temp_c_in,
   input wire logic external_fault_in,
   input wire logic tamper_closed_in,
   input wire logic fault_relay_energised_out,
   input wire logic mains_loss_out,
   input wire logic status_led_out,
   input wire logic [4:0] shown_code_out,
   input wire logic charge_limit_out,
   input wire logic [21:0] faults_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_mains_drop;
      $fell(mains_present_in);
   endsequence
   sequence s_flash;
      status_led_out [*3] ##1 !status_led_out;
   endsequence
   a_ext_open_fault: assert property (!external_fault_in |=>
      faults_out[8] && !fault_relay_energised_out) else $error("open loop not flagged");
   a_fuse_one_fault: assert property (output_one_fuse_blown_in |=>
      faults_out[1] && !fault_relay_energised_out) else $error("fuse fault missed");
   a_low_out_one: assert property (load_output_one_dv_in < 12'h104 |=>
      faults_out[6]) else $error("low output missed");
   a_high_out_two: assert property (load_output_two_dv_in > 12'h124 |=>
      faults_out[16]) else $error("high output missed");
   a_tamper_open: assert property (!tamper_closed_in |=> faults_out[14])
      else $error("tamper missed");
   a_temp_high: assert property ($signed(bat_temp_c_in) > $signed(8'h41) &&
      $signed(bat_temp_c_in) <= $signed(8'h50) |=> faults_out[10]) else $error("hot missed");
   a_sensor_fail: assert property ($signed(bat_temp_c_in) < $signed(8'hEC) ||
      $signed(bat_temp_c_in) > $signed(8'h50) |=> faults_out[9] && !faults_out[10])
      else $error("sensor fault missed");
   a_relay_healthy: assert property (fault_relay_energised_out |->
      faults_out[21:1] == 21'h000000 && !mains_loss_out) else $error("relay on with fault");
   a_mains_wait: assert property (s_mains_drop |=> !mains_loss_out [*8])
      else $error("mains output too early");
   a_charge_limit: assert property ($rose(overload_in) |=> charge_limit_out [*8])
      else $error("charge limit missing");
   a_flash_shape: assert property ($rose(status_led_out) |-> s_flash)
      else $error("flash length wrong");
   a_led_code: assert property (status_led_out |->
      shown_code_out inside {[5'h01:5'h16]}) else $error("led without code");
endmodule
bind collective_fault_indicator collective_fault_props u_collective_fault_props (.*);
`default_nettype wire

// ---- testbench/fuse_strip_model.sv ----
/*
 Far-side add-ons: fuse strip opening the loop into the external input,
 and an output sequencer. Assumes one bit per channel, bench clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fuse_strip_model (
   input wire logic [3:0] blown_in,
   output logic loop_closed_out,
   output logic [3:0] chan_led_out,
   output logic red_led_out,
   output logic strip_relay_out
);
   assign chan_led_out = ~blown_in;
   assign red_led_out = |blown_in;
   assign strip_relay_out = ~|blown_in;
   // contact opens on any blown fuse
   assign loop_closed_out = ~|blown_in;
endmodule

module sequencing_model #(
   parameter int STEP_CYC = 10
) (
   input wire logic clk_in,
   input wire logic start_in,
   output logic [3:0] outputs_on_out
);
   int gap = 0;
   // one more output every STEP_CYC cycles to spread inrush
   always @(posedge clk_in) begin
      if (!start_in) begin
         outputs_on_out <= 4'h0;
         gap <= 0;
      end else if (outputs_on_out != 4'hF) begin
         if (gap == 0) begin
            outputs_on_out <= {outputs_on_out[2:0], 1'b1};
            gap <= STEP_CYC - 1;
         end else begin
            gap <= gap - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/collective_fault_indicator_tb_top.sv ----
/*
 Self-checking bench for the collective fault indicator.
 Assumes shortened timing parameters and a fuse strip on the external input.
*/
`timescale 1ns/1ps
`default_nettype none
module collective_fault_indicator_tb_top;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [21:0] bad = 22'h000000;
   logic [3:0] blown = 4'h0;
   logic dmg = 1'b0;
   logic cont = 1'b0;
   logic [11:0] hi = 12'h125;
   logic [11:0] lo = 12'h103;
   logic [7:0] ts = 8'hEB;
   logic [7:0] th = 8'h42;
   int fails = 0;
   int cmp_count = 0;
   logic seq_go = 1'b0;
   wire logic [3:0] seq_on;
   wire logic red, srel;
   wire logic loop_ok, relay, mloss, led, lim;
   wire logic [4:0] code;
   wire logic [21:0] flt;
   always #5 sys_clk_in = ~sys_clk_in;
   fuse_strip_model u_fuse_strip_model (.blown_in(blown), .loop_closed_out(loop_ok),
      .chan_led_out(), .red_led_out(red), .strip_relay_out(srel));
   sequencing_model #(.STEP_CYC(10)) u_sequencing_model (.clk_in(sys_clk_in),
      .start_in(seq_go), .outputs_on_out(seq_on));
   collective_fault_indicator #(.MAINS_DELAY_CYC(36'h14), .OVERLOAD_LIMIT_CYC(36'h1E),
      .FLASH_ON_CYC(32'h3), .FLASH_OFF_CYC(32'h3), .CODE_PAUSE_CYC(32'hA))
      u_collective_fault_indicator (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .mains_present_in(!bad[0]), .load_output_one_dv_in(bad[4] ? hi : bad[6] ? lo : 12'h118),
      .load_output_two_dv_in(bad[16] ? 12'h125 : bad[17] ? 12'h103 : 12'h118),
      .output_one_fuse_blown_in(bad[1]), .output_two_fuse_blown_in(bad[15]),
      .overload_in(bad[2]), .bat_temp_c_in(bad[9] ? ts : bad[10] ? th : 8'h19),
      .battery_absent_in(bad[11]), .battery_faulty_in(bad[12]),
      .battery_undercharged_in(bad[3]), .battery_low_in(bad[7]),
      .bat_resistance_high_in(bad[13]), .bat_continuity_lost_in(cont),
      .charger_fail_in(bad[5]), .internal_damage_in(dmg),
      .external_fault_in(!bad[8] && loop_ok), .tamper_closed_in(!bad[14]),
      .service_single_in(bad[20:18]), .service_group_in({bad[21], 8'h00}),
      .fault_relay_energised_out(relay), .mains_loss_out(mloss), .status_led_out(led),
      .shown_code_out(code), .charge_limit_out(lim), .faults_out(flt));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task t_idle;
      step(2);
      chk(relay, 1);
      chk(flt, 0);
      $display("idle done");
   endtask
   task t_led;
      int n, dark;
      logic pl;
      logic [31:0] seen;
      logic [4:0] last;
      n = 0;
      dark = 0;
      pl = 0;
      seen = 0;
      last = 5'h00;
      bad = 22'h000006;
      repeat (200) begin
         step(1);
         if (led && !pl) n++;
         dark = led ? 0 : dark + 1;
         if (dark == 6 && n != 0) begin
            chk(n, code);
            if (last != 5'h00) chk(code, (last == 5'h02) ? 32'h3 : 32'h2);
            last = code;
            seen[code] = 1'b1;
            n = 0;
         end
         pl = led;
      end
      chk(seen, 32'h0000000C);
      while (led) step(1);
      bad = 0;
      // let the charge-limit minute and the last code run out
      step(40);
      $display("led done");
   endtask
   task t_codes;
      for (int i = 1; i < 22; i++) begin
         bad = 22'h000001 << i;
         step(2);
         chk(flt, bad);
         chk(relay, 0);
         bad = 0;
         step(2);
      end
      cont = 1;
      step(2);
      chk(flt, 22'h001000);
      cont = 0;
      dmg = 1;
      step(2);
      chk(relay, 0);
      dmg = 0;
      step(2);
      $display("codes done");
   endtask
   task t_bound;
      hi = 12'h124;
      lo = 12'h104;
      ts = 8'hEC;
      th = 8'h41;
      bad = 22'h000210;
      step(2);
      chk(flt, 0);
      bad = 22'h000440;
      step(2);
      chk(flt, 0);
      chk(relay, 1);
      th = 8'h51;
      bad = 22'h000400;
      step(2);
      chk(flt, 22'h000200);
      th = 8'h50;
      step(2);
      chk(flt, 22'h000400);
      hi = 12'h125;
      lo = 12'h103;
      ts = 8'hEB;
      th = 8'h42;
      bad = 0;
      step(2);
      $display("bounds done");
   endtask
   task t_mains;
      bad = 22'h000001;
      step(2);
      chk(flt, 0);
      chk(relay, 1);
      step(16);
      chk(mloss, 0);
      step(8);
      chk(mloss, 1);
      chk(flt, 1);
      chk(relay, 0);
      bad = 0;
      step(3);
      chk(mloss, 0);
      chk(relay, 1);
      $display("mains done");
   endtask
   task t_over;
      bad = 22'h000004;
      step(2);
      chk(lim, 1);
      bad = 0;
      step(3);
      chk(lim, 1);
      step(26);
      chk(lim, 1);
      step(1);
      chk(lim, 0);
      bad = 22'h000004;
      step(40);
      chk(lim, 1);
      bad = 0;
      step(70);
      chk(lim, 0);
      $display("overload done");
   endtask
   task t_strip;
      blown = 4'h2;
      step(2);
      chk(flt, 22'h000100);
      chk(relay, 0);
      chk(red, 1);
      chk(srel, 0);
      blown = 4'h0;
      step(2);
      chk(relay, 1);
      chk(red, 0);
      $display("strip done");
   endtask
   task t_seq;
      seq_go = 1'b1;
      step(1);
      chk(seq_on, 4'h1);
      step(9);
      chk(seq_on, 4'h1);
      step(1);
      chk(seq_on, 4'h3);
      step(20);
      chk(seq_on, 4'hF);
      seq_go = 1'b0;
      step(2);
      chk(seq_on, 4'h0);
      $display("sequencing done");
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_in);
      #1;
      rst_n_in = 1'b1;
      t_idle;
      t_led;
      t_codes;
      t_bound;
      t_mains;
      t_over;
      t_strip;
      t_seq;
      print_verdict;
   end
   initial begin
      #50000;
      fails++;
      print_verdict;
   end
endmodule
`default_nettype wire
